//--- iis_consts.svh
`ifndef IIS_CONSTS_SVH
`define IIS_CONSTS_SVH

// Clock and timing
`define IIS_CLK_HZ 100000000
`define IIS_BOOT_MS 4
`define IIS_BOOT_CYC (`IIS_BOOT_MS * (`IIS_CLK_HZ / 1000))
`define IIS_RATE_HZ 8000000
`define IIS_RATE_HALF (`IIS_CLK_HZ / (2 * `IIS_RATE_HZ))
`define IIS_CMD_CYC 16
`define IIS_PULSE_BASE 8'h08

// Register indices, byte address is four times the index
`define IIS_IDX_IFCFG 8'h01
`define IIS_IDX_ACFG 8'h02
`define IIS_IDX_GCFG 8'h03
`define IIS_IDX_SEN 8'h07
`define IIS_IDX_WAKE 8'h08
`define IIS_IDX_CMD 8'h0a
`define IIS_IDX_QCFG 8'h13
`define IIS_IDX_DSTAT 8'h2d
`define IIS_IDX_CSTAT 8'h2e
`define IIS_IDX_OUT0 8'h35
`define IIS_IDX_OUT1 8'h36

// Field positions
`define IIS_B_SHUTDOWN 0
`define IIS_B_SELFTEST 7
`define IIS_B_LOCKED 7
`define IIS_B_AEN 0
`define IIS_B_GEN 1
`define IIS_B_FUSION 3
`define IIS_B_WAKE_EN 0
`define IIS_B_WAKE_L1 1
`define IIS_B_DRAIN 7
`define IIS_B_CMD_DONE 0
`define IIS_B_WAKE_EVT 1
`define IIS_B_BOOT 2

// Field values
`define IIS_GRATE_STAB 3'b110
`define IIS_ARATE_WAKE 3'b111
`define IIS_SEN_ACC_ONLY 3'b001
`define IIS_QMODE_QUEUE 2'd1
`define IIS_QMODE_STREAM 2'd2

// Reset values
`define IIS_RST_REG 8'h00

`endif

//--- iis_pkg.sv
`include "iis_consts.svh"
package iis_pkg;
	typedef enum {IIS_M_BYPASS, IIS_M_LOCKED, IIS_M_QUEUE, IIS_M_STREAM, IIS_M_SELFTEST, IIS_M_FUSION} iis_mode_t;
	typedef enum {IIS_LK_IDLE, IIS_LK_ARMED, IIS_LK_FROZEN} iis_lock_t;

	// Pulse width doubles per step of the rate code's low two bits, gyro adds one base unit
	function automatic logic [7:0] iis_pulse_cycles(input logic [2:0] rate, input logic gyro);
		logic [7:0] w;
		w = `IIS_PULSE_BASE << rate[1:0];
		if (gyro) begin
			w = w + `IIS_PULSE_BASE;
		end
		return w;
	endfunction
endpackage

//--- iis_evt_if.sv
`timescale 1ns/100ps
interface iis_evt_if;
	import iis_pkg::*;
	iis_mode_t mode;
	logic new_data;
	logic queue_full;
	logic queue_wtm;
	logic selftest_done;
	logic fusion_data;
	logic drain_fall;
	logic status_rd;
	logic last_rd;
	logic [7:0] pulse_w;
	logic irq_two;
	logic freeze;
	logic [2:0] flags;
	modport top (output mode, new_data, queue_full, queue_wtm, selftest_done, fusion_data, drain_fall,
		status_rd, last_rd, pulse_w, input irq_two, freeze, flags);
	modport l2 (input mode, new_data, queue_full, queue_wtm, selftest_done, fusion_data, drain_fall,
		status_rd, last_rd, pulse_w, output irq_two, freeze, flags);
endinterface

//--- iis_timer.sv
`timescale 1ns/100ps
module iis_timer #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Load wins over counting so a retrigger restarts the span
	assign cnt_nxt = load ? value : (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
	assign busy = cnt_r != '0;
	assign done = cnt_r == W'(1);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

//--- iis_line_two.sv
`timescale 1ns/100ps
module iis_line_two import iis_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	iis_evt_if.l2 ev
);
	iis_lock_t lk_r;
	iis_lock_t lk_nxt;
	logic irq_r;
	logic irq_nxt;
	logic q_flag_r;
	logic st_flag_r;
	logic fu_flag_r;
	logic lk_act;
	logic q_act;
	logic q_set;
	logic pulse_busy;

	assign lk_act = ev.mode == IIS_M_LOCKED;
	assign q_act = (ev.mode == IIS_M_QUEUE) || (ev.mode == IIS_M_STREAM);
	// Stream mode overwrites when full, so only the watermark counts there
	assign q_set = q_act && (ev.queue_wtm || (ev.mode == IIS_M_QUEUE && ev.queue_full)); // [RULE_12] [RULE_13]

	// Bypass pulse: self-clearing, host must latch the rising edge
	iis_timer #(.W(8)) u_pulse (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.load(ev.mode == IIS_M_BYPASS && ev.new_data), // [RULE_06]
		.value(ev.pulse_w),
		.busy(pulse_busy),
		.done()
	);

	// Locked sample handshake sequence
	always_comb begin
		lk_nxt = lk_r;
		if (!lk_act) begin
			lk_nxt = IIS_LK_IDLE;
		end else begin
			case (lk_r)
				IIS_LK_IDLE: begin
					if (ev.new_data) begin
						lk_nxt = IIS_LK_ARMED; // [RULE_08]
					end
				end
				IIS_LK_ARMED: begin
					if (ev.status_rd) begin
						lk_nxt = IIS_LK_FROZEN; // [RULE_09]
					end
				end
				IIS_LK_FROZEN: begin
					if (ev.last_rd) begin
						lk_nxt = IIS_LK_IDLE; // [RULE_11]
					end
				end
				default: lk_nxt = IIS_LK_IDLE;
			endcase
		end
	end

	// Only the selected mode drives the line
	always_comb begin
		case (ev.mode)
			IIS_M_BYPASS: irq_nxt = pulse_busy; // [RULE_06] [RULE_22]
			IIS_M_LOCKED: irq_nxt = lk_nxt == IIS_LK_ARMED; // [RULE_08]
			IIS_M_QUEUE, IIS_M_STREAM: irq_nxt = q_set || (q_flag_r && !ev.drain_fall); // [RULE_14]
			IIS_M_SELFTEST: irq_nxt = ev.selftest_done || st_flag_r; // [RULE_15]
			IIS_M_FUSION: irq_nxt = ev.fusion_data || (fu_flag_r && !ev.status_rd); // [RULE_16]
			default: irq_nxt = 1'b0;
		endcase
	end

	// Flags: set wins over the clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lk_r <= IIS_LK_IDLE;
			irq_r <= 1'b0;
			q_flag_r <= 1'b0;
			st_flag_r <= 1'b0;
			fu_flag_r <= 1'b0;
		end else begin
			lk_r <= lk_nxt;
			irq_r <= irq_nxt;
			q_flag_r <= q_set || (q_act && q_flag_r && !ev.drain_fall); // [RULE_14]
			st_flag_r <= (ev.mode == IIS_M_SELFTEST) && (ev.selftest_done || st_flag_r); // [RULE_15]
			fu_flag_r <= (ev.mode == IIS_M_FUSION) && (ev.fusion_data || (fu_flag_r && !ev.status_rd));
		end
	end

	assign ev.irq_two = irq_r;
	assign ev.freeze = lk_act && (lk_r == IIS_LK_FROZEN); // [RULE_09]
	assign ev.flags = {st_flag_r, q_flag_r, irq_r};
endmodule

//--- iis_top.sv
// Overview of operation
// [RULE_01] Line one high about 4 ms after reset
// [RULE_02] Reading command status clears line one
// [RULE_03] Line one signals command handshake completion
// [RULE_04] Stabilization: line one carries 8 MHz clock
// [RULE_05] Motion wake may be routed to line one
// [RULE_06] Bypass: short self-clearing pulse on new data
// [RULE_07] Host latches line two rising edge
// [RULE_08] Locked mode: line two held until status read
// [RULE_09] Status read freezes outputs, drops line two
// [RULE_10] Host reads outputs after line two drops
// [RULE_11] Last output byte read resumes updates
// [RULE_12] Queue mode: full or watermark raises line two
// [RULE_13] Stream mode: watermark only, overwrite oldest
// [RULE_14] Clearing drain enable clears line two
// [RULE_15] Self-test results raise line two until bits cleared
// [RULE_16] Fusion engine raises line two on new data
// [RULE_17] Shutdown stops functions, keeps registers
// [RULE_18] Gyro rate code 110 enters stabilization
// [RULE_19] Motion wake needs accel only, rate 111
// [RULE_20] Command write at 0x0a, completion bit0
// [RULE_21] Host drains queue then clears drain enable
// [RULE_22] One line two mode, active-high synchronous lines
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "iis_consts.svh"
module iis_top import iis_pkg::*; #(
	parameter int BOOT_CYC = `IIS_BOOT_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic new_data,
	input wire logic [47:0] sample_in,
	input wire logic queue_full,
	input wire logic queue_wtm,
	input wire logic selftest_done,
	input wire logic fusion_data,
	input wire logic motion_detect,
	output logic irq_line_one,
	output logic irq_line_two,
	output logic stab_stream
);
	// Configuration registers
	logic [7:0] ifcfg_r;
	logic [7:0] acfg_r;
	logic [7:0] gcfg_r;
	logic [7:0] sen_r;
	logic [7:0] wake_r;
	logic [7:0] qcfg_r;
	logic [7:0] cmd_code_r;

	// Event state
	logic cmd_done_r;
	logic wake_flag_r;
	logic boot_hi_r;
	logic boot_go_r;
	logic l1_r;
	logic l1_nxt;
	logic rclk_r;
	logic [7:0] rdiv_r;
	logic stab_r;

	// Sample holding registers
	logic [31:0] out0_r;
	logic [31:0] out1_r;

	// Bus answer
	logic [31:0] prdata_r;
	logic [31:0] rd_word;
	logic pready_r;
	logic pslverr_r;
	logic [7:0] snap_r;

	// Decode
	logic [7:0] idx;
	logic aligned;
	logic hit;
	logic setup;
	logic acc;
	logic wr;
	logic rd;
	logic shutdown;
	logic stab;
	logic wake_ok;
	logic nd_g;
	logic cst_rd;
	logic dst_rd;
	logic drain_fall;
	logic cmd_wr;
	logic cmd_fin;
	logic boot_fin;
	logic [1:0] qmode;
	logic st_active;
	logic gyro_sel;
	logic [2:0] rate_sel;
	iis_mode_t mode;

	iis_evt_if ev ();

	// Only indices in the map answer; anything else errors
	function automatic logic idx_mapped(input logic [7:0] i);
		case (i)
			`IIS_IDX_IFCFG, `IIS_IDX_ACFG, `IIS_IDX_GCFG, `IIS_IDX_SEN, `IIS_IDX_WAKE,
			`IIS_IDX_CMD, `IIS_IDX_QCFG, `IIS_IDX_DSTAT, `IIS_IDX_CSTAT,
			`IIS_IDX_OUT0, `IIS_IDX_OUT1: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// APB phase decode; side effects only at the completing access edge
	assign idx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	assign hit = aligned && idx_mapped(idx);
	assign setup = psel && !penable;
	assign acc = psel && penable && pready_r;
	assign wr = acc && pwrite && !pslverr_r;
	assign rd = acc && !pwrite && !pslverr_r;

	// Mode decode
	assign shutdown = ifcfg_r[`IIS_B_SHUTDOWN]; // [RULE_17]
	assign stab = !shutdown && (gcfg_r[2:0] == `IIS_GRATE_STAB); // [RULE_18]
	assign wake_ok = !shutdown && (sen_r[2:0] == `IIS_SEN_ACC_ONLY) && (acfg_r[2:0] == `IIS_ARATE_WAKE)
		&& wake_r[`IIS_B_WAKE_EN]; // [RULE_19]
	assign nd_g = new_data && !shutdown;
	assign qmode = qcfg_r[1:0];
	assign st_active = acfg_r[`IIS_B_SELFTEST] || gcfg_r[`IIS_B_SELFTEST];
	assign gyro_sel = sen_r[`IIS_B_GEN];
	assign rate_sel = gyro_sel ? gcfg_r[2:0] : acfg_r[2:0];

	// One data mode at a time, self-test highest priority
	assign mode = st_active ? IIS_M_SELFTEST :
		sen_r[`IIS_B_FUSION] ? IIS_M_FUSION :
		(qmode == `IIS_QMODE_QUEUE) ? IIS_M_QUEUE :
		(qmode == `IIS_QMODE_STREAM) ? IIS_M_STREAM :
		sen_r[`IIS_B_LOCKED] ? IIS_M_LOCKED : IIS_M_BYPASS; // [RULE_22] [RULE_08]

	// Register-access strobes
	assign cst_rd = rd && (idx == `IIS_IDX_CSTAT);
	assign dst_rd = rd && (idx == `IIS_IDX_DSTAT);
	assign cmd_wr = wr && (idx == `IIS_IDX_CMD) && !stab; // [RULE_20]
	assign drain_fall = wr && (idx == `IIS_IDX_QCFG) && qcfg_r[`IIS_B_DRAIN] && !pwdata[`IIS_B_DRAIN]; // [RULE_14]

	// Event path into the line two logic
	assign ev.mode = mode;
	assign ev.new_data = nd_g;
	assign ev.queue_full = queue_full && !shutdown;
	assign ev.queue_wtm = queue_wtm && !shutdown;
	assign ev.selftest_done = selftest_done && !shutdown;
	assign ev.fusion_data = fusion_data && !shutdown;
	assign ev.drain_fall = drain_fall;
	assign ev.status_rd = dst_rd;
	assign ev.last_rd = rd && (idx == `IIS_IDX_OUT1); // [RULE_11]
	assign ev.pulse_w = iis_pulse_cycles(rate_sel, gyro_sel); // [RULE_06]

	iis_line_two u_line_two (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ev(ev)
	);

	// Boot-ready span; the count is a parameter so benches can shorten it
	iis_timer #(.W(20)) u_boot (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.load(boot_go_r),
		.value(20'(BOOT_CYC)),
		.busy(),
		.done(boot_fin)
	);

	// Command execution latency before completion is flagged
	iis_timer #(.W(8)) u_cmd (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.load(cmd_wr),
		.value(8'(`IIS_CMD_CYC)),
		.busy(),
		.done(cmd_fin)
	);

	// Read data selection
	always_comb begin
		case (idx)
			`IIS_IDX_IFCFG: rd_word = {24'h0, ifcfg_r};
			`IIS_IDX_ACFG: rd_word = {24'h0, acfg_r};
			`IIS_IDX_GCFG: rd_word = {24'h0, gcfg_r};
			`IIS_IDX_SEN: rd_word = {24'h0, sen_r};
			`IIS_IDX_WAKE: rd_word = {24'h0, wake_r};
			`IIS_IDX_CMD: rd_word = {24'h0, cmd_code_r};
			`IIS_IDX_QCFG: rd_word = {24'h0, qcfg_r};
			`IIS_IDX_DSTAT: rd_word = {29'h0, ev.flags};
			`IIS_IDX_CSTAT: rd_word = {29'h0, boot_hi_r, wake_flag_r, cmd_done_r};
			`IIS_IDX_OUT0: rd_word = out0_r;
			`IIS_IDX_OUT1: rd_word = out1_r;
			default: rd_word = 32'h0;
		endcase
	end

	// Line one: rate clock in stabilization, else the OR of its sources
	assign l1_nxt = stab ? rclk_r : // [RULE_04]
		(boot_hi_r || cmd_done_r || (wake_flag_r && wake_r[`IIS_B_WAKE_L1])); // [RULE_03] [RULE_05]

	// Bus answer is registered in setup, so every access has one wait-free access cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			snap_r <= 8'h00;
		end else begin
			pready_r <= setup;
			// Error stands only beside pready, so a stale error never outlives its access
			pslverr_r <= setup && !hit;
			if (setup) begin
				prdata_r <= pwrite ? 32'h0 : rd_word;
				snap_r <= rd_word[7:0];
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ifcfg_r <= `IIS_RST_REG;
			acfg_r <= `IIS_RST_REG;
			gcfg_r <= `IIS_RST_REG;
			sen_r <= `IIS_RST_REG;
			wake_r <= `IIS_RST_REG;
			qcfg_r <= `IIS_RST_REG;
			cmd_code_r <= `IIS_RST_REG;
		end else if (wr) begin
			case (idx)
				`IIS_IDX_IFCFG: ifcfg_r <= pwdata[7:0];
				`IIS_IDX_ACFG: acfg_r <= pwdata[7:0];
				`IIS_IDX_GCFG: gcfg_r <= pwdata[7:0];
				`IIS_IDX_SEN: sen_r <= pwdata[7:0];
				`IIS_IDX_WAKE: wake_r <= pwdata[7:0];
				`IIS_IDX_CMD: cmd_code_r <= pwdata[7:0]; // [RULE_20]
				`IIS_IDX_QCFG: qcfg_r <= pwdata[7:0];
				default: cmd_code_r <= cmd_code_r;
			endcase
		end
	end

	// Line one sources; only bits the host actually saw are cleared, and a set wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_go_r <= 1'b1;
			boot_hi_r <= 1'b0;
			cmd_done_r <= 1'b0;
			wake_flag_r <= 1'b0;
		end else begin
			boot_go_r <= 1'b0;
			boot_hi_r <= boot_go_r || (boot_hi_r && !boot_fin
				&& !(cst_rd && snap_r[`IIS_B_BOOT])); // [RULE_01] [RULE_02]
			cmd_done_r <= (cmd_fin && !stab) || (cmd_done_r
				&& !(cst_rd && snap_r[`IIS_B_CMD_DONE])); // [RULE_03] [RULE_02]
			wake_flag_r <= (wake_ok && !stab && motion_detect) || (wake_flag_r
				&& !(cst_rd && snap_r[`IIS_B_WAKE_EVT])); // [RULE_05] [RULE_19]
		end
	end

	// Gyro rate clock divider; runs only in stabilization
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdiv_r <= 8'h00;
			rclk_r <= 1'b0;
		end else if (!stab) begin
			rdiv_r <= 8'h00;
			rclk_r <= 1'b0;
		end else if (rdiv_r == 8'(`IIS_RATE_HALF - 1)) begin
			rdiv_r <= 8'h00;
			rclk_r <= !rclk_r; // [RULE_04]
		end else begin
			rdiv_r <= rdiv_r + 8'h01;
		end
	end

	// Output holding registers refresh unless frozen; shutdown keeps contents
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out0_r <= 32'h0;
			out1_r <= 32'h0;
		end else if (nd_g && !ev.freeze) begin
			out0_r <= sample_in[31:0]; // [RULE_09] [RULE_17]
			out1_r <= {16'h0, sample_in[47:32]};
		end
	end

	// Registered pin drivers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			l1_r <= 1'b0;
			stab_r <= 1'b0;
		end else begin
			l1_r <= l1_nxt; // [RULE_22]
			stab_r <= stab; // [RULE_18]
		end
	end

	assign irq_line_one = l1_r;
	assign irq_line_two = ev.irq_two;
	assign stab_stream = stab_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule

//--- iis_host_model.sv
`timescale 1ns/100ps
module iis_host_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic irq_line_two,
	output logic [7:0] edge_cnt
);
	logic prev_r;
	// Host latches rising edges only, since the pulse width varies
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			edge_cnt <= 8'h00;
		end else begin
			prev_r <= irq_line_two;
			if (irq_line_two && !prev_r) begin
				edge_cnt <= edge_cnt + 8'h01;
			end
		end
	end
endmodule

//--- iis_top_checker.sv
`timescale 1ns/100ps
module iis_top_checker #(
	parameter int BOOT_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic new_data,
	input wire logic queue_full,
	input wire logic queue_wtm,
	input wire logic selftest_done,
	input wire logic fusion_data,
	input wire logic irq_line_one,
	input wire logic irq_line_two,
	input wire logic stab_stream
);
	logic [31:0] cyc_r;
	logic acc;
	logic any_evt;
	// Access edge and any cause that may raise line two
	assign acc = psel && penable && pready;
	assign any_evt = new_data || queue_full || queue_wtm || selftest_done || fusion_data;
	// Saturating count since reset, so a long run never wraps into the boot window
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_r <= 32'h0;
		end else if (cyc_r != 32'hffff_ffff) begin
			cyc_r <= cyc_r + 32'h1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_setup_ready: assert property (psel && !penable |=> pready) else $error("no pready");
	a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
	a_unmapped_err: assert property (psel && !penable && paddr == 12'h0fc |=> pslverr) else $error("no pslverr");
	a_boot_high: assert property (cyc_r > 32'd2 && cyc_r < BOOT_CYC |-> irq_line_one) else $error("boot low");
	a_cmd_done: assert property (acc && pwrite && paddr == 12'h028 && !stab_stream |-> ##18 irq_line_one)
		else $error("cmd late");
	a_status_clear: assert property (acc && !pwrite && paddr == 12'h0b8 && prdata[2:0] != 3'h0 && !stab_stream
		|-> ##3 !irq_line_one) else $error("line one kept");
	a_stab_clock: assert property ($rose(irq_line_one) && stab_stream && $past(stab_stream)
		|-> irq_line_one[*6] ##1 !irq_line_one or ##[1:7] !stab_stream) else $error("bad rate clock");
	a_two_cause: assert property ($rose(irq_line_two) |-> $past(any_evt) || $past(any_evt, 2))
		else $error("line two no cause");
endmodule
bind iis_top iis_top_checker #(.BOOT_CYC(BOOT_CYC)) u_chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .new_data, .queue_full, .queue_wtm, .selftest_done, .fusion_data, .irq_line_one,
	.irq_line_two, .stab_stream);

//--- imu_interrupt_signaling_tb_top.sv
`timescale 1ns/100ps
`include "iis_consts.svh"
module imu_interrupt_signaling_tb_top;
	localparam int BOOT = 20;
	typedef struct {logic [7:0] idx; logic [31:0] wd; logic err;} iis_row_t;
	logic sys_clk = 1'b0;
	logic rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic irq_line_one, irq_line_two, stab_stream;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [47:0] sample_in;
	logic [5:0] evt;
	logic [7:0] edge_cnt, e0;
	int error_cnt = 0;
	int n_tests = 0;
	int c;
	iis_row_t rows[4] = '{'{`IIS_IDX_ACFG, 32'h01, 1'b0}, '{`IIS_IDX_GCFG, 32'h02, 1'b0},
		'{`IIS_IDX_WAKE, 32'h02, 1'b0}, '{8'h3f, 32'hff, 1'b1}};
	iis_top #(.BOOT_CYC(BOOT)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.new_data(evt[0]), .sample_in(sample_in), .queue_full(evt[1]), .queue_wtm(evt[2]),
		.selftest_done(evt[3]), .fusion_data(evt[4]), .motion_detect(evt[5]), .irq_line_one(irq_line_one),
		.irq_line_two(irq_line_two), .stab_stream(stab_stream));
	iis_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .irq_line_two(irq_line_two), .edge_cnt(edge_cnt));
	// Free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	// Closing report, reached from the end of the run or a timeout
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// One APB transfer; request held until pready is seen at an edge
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			error_cnt++;
			stop_test();
		end
	endtask
	task pulse(input int k);
		@(posedge sys_clk);
		evt[k] <= 1'b1;
		@(posedge sys_clk);
		evt <= 6'h00;
	endtask
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Bounded wait for a line level; s selects line two
	task wfor(input int s, input logic v);
		int i;
		i = 0;
		n_tests++;
		while ((s ? irq_line_two : irq_line_one) !== v && i < 60) begin
			@(posedge sys_clk);
			i++;
		end
		if (i >= 60) begin
			error_cnt++;
			stop_test();
		end
	endtask
	task hwidth(input int s, output int w);
		wfor(s, 1'b1);
		w = 0;
		while ((s ? irq_line_two : irq_line_one) === 1'b1 && w < 200) begin
			@(posedge sys_clk);
			w++;
		end
	endtask
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sample_in = 48'h0;
		evt = 6'h00;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		wt(6);
		chk(irq_line_one, 1'b1);
		wt(BOOT);
		chk(irq_line_one, 1'b0);
		$display("end boot");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].idx, rows[i].wd);
			chk(er, rows[i].err);
			apb(1'b0, rows[i].idx, 32'h0);
			chk(er, rows[i].err);
			if (!rows[i].err) chk(rd, rows[i].wd);
		end
		$display("end table");
		apb(1'b1, `IIS_IDX_CMD, 32'h0d);
		wfor(0, 1'b1);
		apb(1'b0, `IIS_IDX_CSTAT, 32'h0);
		chk(rd[0], 1'b1);
		wt(3);
		chk(irq_line_one, 1'b0);
		$display("end command");
		apb(1'b1, `IIS_IDX_SEN, 32'h01);
		e0 = edge_cnt;
		pulse(0);
		hwidth(1, c);
		chk(c, 16);
		chk(edge_cnt, e0 + 8'h01);
		// Gyro enabled: gyro rate code 2 sets the width, plus one base unit
		apb(1'b1, `IIS_IDX_SEN, 32'h02);
		pulse(0);
		hwidth(1, c);
		chk(c, 40);
		$display("end bypass");
		// Locked mode: hold, freeze on status read, resume after last byte
		apb(1'b1, `IIS_IDX_SEN, 32'h81);
		sample_in <= 48'h1111_2222_3333;
		pulse(0);
		wfor(1, 1'b1);
		wt(20);
		chk(irq_line_two, 1'b1);
		apb(1'b0, `IIS_IDX_DSTAT, 32'h0);
		wt(3);
		chk(irq_line_two, 1'b0);
		sample_in <= 48'h4444_5555_6666;
		pulse(0);
		wt(3);
		chk(irq_line_two, 1'b0);
		apb(1'b0, `IIS_IDX_OUT0, 32'h0);
		chk(rd, 32'h2222_3333);
		apb(1'b0, `IIS_IDX_OUT1, 32'h0);
		chk(rd, 32'h1111);
		pulse(0);
		wfor(1, 1'b1);
		apb(1'b0, `IIS_IDX_OUT0, 32'h0);
		chk(rd, 32'h5555_6666);
		apb(1'b0, `IIS_IDX_DSTAT, 32'h0);
		apb(1'b1, `IIS_IDX_SEN, 32'h01);
		$display("end locked");
		// Queue then stream: full counts only in queue mode
		for (int m = 1; m < 3; m++) begin
			apb(1'b1, `IIS_IDX_QCFG, m);
			pulse(1);
			wt(3);
			chk(irq_line_two, m == 1);
			pulse(2);
			wfor(1, 1'b1);
			apb(1'b1, `IIS_IDX_QCFG, m | 32'h80);
			apb(1'b1, `IIS_IDX_QCFG, m);
			wt(3);
			chk(irq_line_two, 1'b0);
		end
		apb(1'b1, `IIS_IDX_QCFG, 32'h0);
		$display("end queue");
		apb(1'b1, `IIS_IDX_ACFG, 32'h81);
		pulse(3);
		wfor(1, 1'b1);
		wt(10);
		chk(irq_line_two, 1'b1);
		apb(1'b1, `IIS_IDX_ACFG, 32'h01);
		wt(3);
		chk(irq_line_two, 1'b0);
		apb(1'b1, `IIS_IDX_SEN, 32'h09);
		pulse(4);
		wfor(1, 1'b1);
		apb(1'b0, `IIS_IDX_DSTAT, 32'h0);
		wt(3);
		chk(irq_line_two, 1'b0);
		$display("end selftest fusion");
		apb(1'b1, `IIS_IDX_SEN, 32'h01);
		apb(1'b1, `IIS_IDX_ACFG, 32'h07);
		apb(1'b1, `IIS_IDX_WAKE, 32'h03);
		pulse(5);
		wfor(0, 1'b1);
		apb(1'b0, `IIS_IDX_CSTAT, 32'h0);
		chk(rd[1], 1'b1);
		wt(3);
		chk(irq_line_one, 1'b0);
		$display("end wake");
		// Shutdown ignores events but keeps configuration
		apb(1'b1, `IIS_IDX_IFCFG, 32'h01);
		e0 = edge_cnt;
		pulse(0);
		wt(20);
		chk(edge_cnt, e0);
		apb(1'b0, `IIS_IDX_ACFG, 32'h0);
		chk(rd, 32'h07);
		apb(1'b1, `IIS_IDX_IFCFG, 32'h0);
		$display("end shutdown");
		apb(1'b1, `IIS_IDX_GCFG, 32'h06);
		wt(2);
		chk(stab_stream, 1'b1);
		wfor(0, 1'b0);
		hwidth(0, c);
		chk(c, 6);
		apb(1'b1, `IIS_IDX_CMD, 32'h0d);
		wt(30);
		apb(1'b0, `IIS_IDX_CSTAT, 32'h0);
		chk(rd[0], 1'b0);
		apb(1'b1, `IIS_IDX_GCFG, 32'h02);
		wt(3);
		chk(stab_stream, 1'b0);
		$display("end stabilization");
		// Mid-run reset: line one drops, configuration clears, boot signal repeats
		rst_n <= 1'b0;
		wt(2);
		chk(irq_line_one, 1'b0);
		rst_n <= 1'b1;
		wt(6);
		chk(irq_line_one, 1'b1);
		apb(1'b0, `IIS_IDX_GCFG, 32'h0);
		chk(rd, 32'h0);
		$display("end reset");
		stop_test();
	end
endmodule
